// *** rtl/sdrl_top.sv ***
/*
  Serial load path of the synthesizer: synchronises the serial clock, data
  and load strobe, shifts words, commits them by length into the
  configuration, swallow and double-buffered reference registers, and shows
  them over an AXI4-Lite slave. Assumes link pins are asynchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdrl_cfg.svh"
module sdrl_top (
  input wire logic clk, // 10 MHz system clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic sclk, // Serial shift clock pin
  input wire logic sdata, // Serial data pin
  input wire logic load_strobe_n, // Load strobe pin, shift while low
  input wire logic ref_in, // Reference input pin
  input wire logic fb_in, // Prescaled VCO input pin
  output logic data_out, // Serial overflow to the next device
  output logic [2:0] osc_sel, // Oscillator or divider select bits
  output logic f_r, // Reference divided pulse
  output logic f_v, // Feedback divided pulse
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  import sdrl_pkg::*;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [4:0] pin_s1_r, pin_s2_r, pin_d_r;
  logic sclk_rise, ld_rise, ld_low;
  logic [`SDRL_R_BITS-1:0] sr_r, sr_nxt;
  logic [`SDRL_CNT_BITS-1:0] cnt_r, cnt_nxt;
  logic [`SDRL_C_BITS-1:0] cfg_r, cfg_nxt;
  sdrl_swal_t swal_r, swal_nxt;
  sdrl_ref_t ref1_r, ref1_nxt, ref2_r, ref2_nxt;
  logic [2:0] top_r, top_nxt;
  logic upd_r, upd_nxt;
  logic ctrl_r, ctrl_nxt;
  sdrl_word_e word;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic bv_nxt, rv_nxt;
  logic [1:0] br_nxt, rr_nxt;
  sdrl_ratio_if rif ();

  function automatic sdrl_word_e classify(input logic [`SDRL_CNT_BITS-1:0] n);
    if (n == '0) classify = SDRL_W_NONE;
    else if (n < `SDRL_CNT_BITS'(`SDRL_A_BITS)) classify = SDRL_W_CFG;
    else if (n < `SDRL_CNT_BITS'(`SDRL_R_BITS)) classify = SDRL_W_SWAL;
    else classify = SDRL_W_REF;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Bits: 0 sclk, 1 sdata, 2 strobe, 3 ref_in, 4 fb_in; stage 2 and its delayed copy are read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 5'h04;
      pin_s2_r <= 5'h04;
      pin_d_r <= 5'h04;
    end else begin
      pin_s1_r <= {fb_in, ref_in, load_strobe_n, sdata, sclk};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  assign sclk_rise = pin_s2_r[0] && !pin_d_r[0];
  assign ld_rise = pin_s2_r[2] && !pin_d_r[2];
  assign ld_low = !pin_s2_r[2];
  assign word = classify(cnt_r);

  always_comb begin
    sr_nxt = sr_r;
    cnt_nxt = cnt_r;
    cfg_nxt = cfg_r;
    swal_nxt = swal_r;
    ref1_nxt = ref1_r;
    ref2_nxt = ref2_r;
    top_nxt = top_r;
    upd_nxt = 1'b0;
    if (ld_low && sclk_rise) begin
      sr_nxt = {sr_r[`SDRL_R_BITS-2:0], pin_s2_r[1]};
      if (cnt_r != '1) cnt_nxt = cnt_r + `SDRL_CNT_BITS'(1);
    end
    // A sclk edge with the strobe high shifts nothing, so a data-free strobe stays empty
    if (ld_rise) begin
      cnt_nxt = '0;
      case (word)
        SDRL_W_NONE: begin
          ref2_nxt = ref1_r;
          upd_nxt = 1'b1;
        end
        SDRL_W_CFG: cfg_nxt = sr_r[`SDRL_C_BITS-1:0];
        SDRL_W_SWAL: begin
          swal_nxt = sr_r[`SDRL_A_BITS-1:0];
          ref2_nxt = ref1_r;
          upd_nxt = 1'b1;
        end
        SDRL_W_REF: begin
          top_nxt = sr_r[`SDRL_REF_TOP_MSB:`SDRL_REF_TOP_LSB];
          ref1_nxt = sr_r[`SDRL_REF_LOW_BITS-1:0];
        end
        default: cnt_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_r <= '0;
      cnt_r <= '0;
      cfg_r <= '0;
      swal_r <= `SDRL_SWAL_RST;
      ref1_r <= `SDRL_REF_RST;
      ref2_r <= `SDRL_REF_RST;
      top_r <= 3'h0;
      upd_r <= 1'b0;
    end else begin
      sr_r <= sr_nxt;
      cnt_r <= cnt_nxt;
      cfg_r <= cfg_nxt;
      swal_r <= swal_nxt;
      ref1_r <= ref1_nxt;
      ref2_r <= ref2_nxt;
      top_r <= top_nxt;
      upd_r <= upd_nxt;
    end
  end
  assign data_out = sr_r[`SDRL_R_BITS-1];
  assign osc_sel = top_r;

  assign rif.ref_ratio = ref2_r;
  assign rif.swal = swal_r;
  assign rif.update = upd_r;
  assign rif.run = ctrl_r;
  assign rif.ref_tick = pin_s2_r[3] && !pin_d_r[3];
  assign rif.fb_tick = pin_s2_r[4] && !pin_d_r[4];
  assign f_r = rif.f_r;
  assign f_v = rif.f_v;
  sdrl_divider i_sdrl_divider (.clk(clk), .rst_n(rst_n), .rif(rif));

  // Address and data are taken independently; the write lands once both are held
  always_comb begin
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    bv_nxt = s_axi_bvalid && !s_axi_bready;
    br_nxt = s_axi_bresp;
    ctrl_nxt = ctrl_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awa_nxt = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_nxt = s_axi_wdata;
      w_have_nxt = s_axi_wstrb[0];
      w_have_nxt = 1'b1;
    end
    if (aw_have_r && w_have_r && !s_axi_bvalid) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = 2'h0;
      if (awa_r == `SDRL_OFF_CTRL) ctrl_nxt = wd_r[0];
      else if (awa_r > `SDRL_OFF_STAT || awa_r[1:0] != 2'h0) br_nxt = 2'h2;
    end
    rv_nxt = s_axi_rvalid && !s_axi_rready;
    rd_nxt = s_axi_rdata;
    rr_nxt = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_nxt = 1'b1;
      rr_nxt = 2'h0;
      case (s_axi_araddr)
        `SDRL_OFF_CFG: rd_nxt = 32'(cfg_r);
        `SDRL_OFF_SWAL: rd_nxt = 32'(swal_r);
        `SDRL_OFF_REF1: rd_nxt = 32'({top_r, ref1_r});
        `SDRL_OFF_REF2: rd_nxt = 32'(ref2_r);
        `SDRL_OFF_CTRL: rd_nxt = 32'(ctrl_r);
        `SDRL_OFF_STAT: rd_nxt = 32'({ld_low, cnt_r});
        default: begin
          rd_nxt = 32'h0;
          rr_nxt = 2'h2;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awa_r <= 8'h00;
      wd_r <= 32'h0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      ctrl_r <= `SDRL_CTRL_RST;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      ctrl_r <= ctrl_nxt;
      s_axi_awready <= !aw_have_nxt && !s_axi_awready;
      s_axi_wready <= !w_have_nxt && !s_axi_wready;
      s_axi_bvalid <= bv_nxt;
      s_axi_bresp <= br_nxt;
      s_axi_arready <= !rv_nxt && !s_axi_arready;
      s_axi_rvalid <= rv_nxt;
      s_axi_rdata <= rd_nxt;
      s_axi_rresp <= rr_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_CFG_ONLY: assert property (ld_rise && word == SDRL_W_CFG |=>
    cfg_r == $past(sr_r[7:0]) && $stable(swal_r) && $stable(ref2_r) && $stable(ref1_r))
    else $error("Config commit disturbed another register");
  AST_SWAL_LOAD: assert property (ld_rise && word == SDRL_W_SWAL |=>
    swal_r == $past(sr_r[15:0]) && $stable(cfg_r))
    else $error("Swallow commit wrong");
  AST_SWAL_COPY: assert property (ld_rise && word == SDRL_W_SWAL |=>
    ref2_r == $past(ref1_r) && $stable(ref1_r))
    else $error("Second reference buffer not copied on swallow commit");
  AST_UPD_PULSE: assert property (ld_rise && word == SDRL_W_SWAL |=> upd_r ##1 !upd_r)
    else $error("Ratio update not a single pulse after swallow commit");
  AST_TOP_BITS: assert property (ld_rise && word == SDRL_W_REF |=> ##1 osc_sel == $past(sr_r[15:13], 2))
    else $error("Select bits not driven from reference word");
  AST_REF_FIRST: assert property (ld_rise && word == SDRL_W_REF |=>
    ref1_r == $past(sr_r[12:0]) && $stable(ref2_r) && $stable(cfg_r) && $stable(swal_r) && !upd_r)
    else $error("Reference commit reached past the first buffer");
  AST_EMPTY_STROBE: assert property (ld_rise && word == SDRL_W_NONE |=>
    ref2_r == $past(ref1_r) && $stable(ref1_r) && $stable(cfg_r) && $stable(swal_r))
    else $error("Data-free strobe did not transfer the buffer");
  AST_COUNT_CLEAR: assert property (ld_rise |=> cnt_r == '0)
    else $error("Bit count not cleared on commit");
  AST_CHAIN_OUT: assert property (ld_low && sclk_rise |=> data_out == $past(sr_r[22]))
    else $error("Overflow bit not passed on");
  AST_AXI_B: assert property (aw_have_r && w_have_r && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("Write response missing");
  COV_CFG: cover property (ld_rise && word == SDRL_W_CFG);
  COV_SWAL: cover property (ld_rise && word == SDRL_W_SWAL);
  COV_REF: cover property (ld_rise && word == SDRL_W_REF);
  COV_EMPTY: cover property (ld_rise && word == SDRL_W_NONE);
endmodule
`default_nettype wire

// *** rtl/sdrl_cfg.svh ***
/*
  Constants for the divider register loader: word lengths, field positions,
  register offsets and reset values. Assumes inclusion by bare name.
*/
`ifndef SDRL_CFG_SVH
`define SDRL_CFG_SVH
`define SDRL_C_BITS 8
`define SDRL_A_BITS 16
`define SDRL_R_BITS 24
`define SDRL_REF_LOW_BITS 13
`define SDRL_REF_TOP_LSB 13
`define SDRL_REF_TOP_MSB 15
`define SDRL_SWALLOW_BITS 6
`define SDRL_MAIN_BITS 10
`define SDRL_SWALLOW_MOD 64
`define SDRL_CNT_BITS 5
`define SDRL_OFF_CFG 8'h00
`define SDRL_OFF_SWAL 8'h04
`define SDRL_OFF_REF1 8'h08
`define SDRL_OFF_REF2 8'h0C
`define SDRL_OFF_CTRL 8'h10
`define SDRL_OFF_STAT 8'h14
`define SDRL_CTRL_RST 1'h0
`define SDRL_REF_RST 13'h0001
`define SDRL_SWAL_RST 16'h0041
`endif

// *** rtl/sdrl_pkg.sv ***
/*
  Types shared by the divider register loader modules.
  Assumes sdrl_cfg.svh is reachable on the include path.
*/
`include "sdrl_cfg.svh"
package sdrl_pkg;
  typedef enum logic [1:0] {SDRL_W_NONE, SDRL_W_CFG, SDRL_W_SWAL, SDRL_W_REF} sdrl_word_e;
  typedef logic [`SDRL_REF_LOW_BITS-1:0] sdrl_ref_t;
  typedef logic [`SDRL_A_BITS-1:0] sdrl_swal_t;
endpackage

// *** rtl/sdrl_ratio_if.sv ***
/*
  Carrier between the register loader and its counter block.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/100ps
`default_nettype none
interface sdrl_ratio_if;
  import sdrl_pkg::*;
  sdrl_ref_t ref_ratio;
  sdrl_swal_t swal;
  logic update;
  logic run;
  logic ref_tick;
  logic fb_tick;
  logic f_r;
  logic f_v;
  modport ctl (output ref_ratio, swal, update, run, ref_tick, fb_tick, input f_r, f_v);
  modport div (input ref_ratio, swal, update, run, ref_tick, fb_tick, output f_r, f_v);
endinterface
`default_nettype wire

// *** rtl/sdrl_divider.sv ***
/*
  Reference and feedback counters. New ratios are staged on update and taken
  by each counter only at the end of its current cycle.
  Assumes ticks are one-cycle pulses in the clk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module sdrl_divider (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  sdrl_ratio_if.div rif // Ratios in, divided pulses out
);
  import sdrl_pkg::*;
  logic [15:0] ref_cnt_r, ref_cnt_nxt, fb_cnt_r, fb_cnt_nxt;
  logic [15:0] ref_div_r, ref_div_nxt, fb_div_r, fb_div_nxt;
  logic [15:0] ref_stg_r, ref_stg_nxt, fb_stg_r, fb_stg_nxt;
  logic ref_pend_r, ref_pend_nxt, fb_pend_r, fb_pend_nxt;
  logic fr_r, fr_nxt, fv_r, fv_nxt;
  logic ref_end, fb_end;

  function automatic logic [15:0] fb_total(input sdrl_swal_t s);
    fb_total = 16'(s[15:6]) * 16'(`SDRL_SWALLOW_MOD) + 16'(s[5:0]);
  endfunction

  assign ref_end = rif.run && rif.ref_tick && ref_cnt_r <= 16'h0001;
  assign fb_end = rif.run && rif.fb_tick && fb_cnt_r <= 16'h0001;
  assign rif.f_r = fr_r;
  assign rif.f_v = fv_r;

  always_comb begin
    ref_stg_nxt = ref_stg_r;
    fb_stg_nxt = fb_stg_r;
    ref_pend_nxt = ref_pend_r;
    fb_pend_nxt = fb_pend_r;
    ref_div_nxt = ref_div_r;
    fb_div_nxt = fb_div_r;
    ref_cnt_nxt = ref_cnt_r;
    fb_cnt_nxt = fb_cnt_r;
    fr_nxt = ref_end;
    fv_nxt = fb_end;
    if (ref_end) begin
      ref_div_nxt = ref_pend_r ? ref_stg_r : ref_div_r;
      ref_cnt_nxt = ref_div_nxt;
      ref_pend_nxt = 1'b0;
    end else if (rif.run && rif.ref_tick) begin
      ref_cnt_nxt = ref_cnt_r - 16'h0001;
    end
    if (fb_end) begin
      fb_div_nxt = fb_pend_r ? fb_stg_r : fb_div_r;
      fb_cnt_nxt = fb_div_nxt;
      fb_pend_nxt = 1'b0;
    end else if (rif.run && rif.fb_tick) begin
      fb_cnt_nxt = fb_cnt_r - 16'h0001;
    end
    if (rif.update) begin
      ref_stg_nxt = 16'(rif.ref_ratio);
      fb_stg_nxt = fb_total(rif.swal);
      ref_pend_nxt = 1'b1;
      fb_pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_r <= 16'h0001;
      fb_cnt_r <= 16'h0001;
      ref_div_r <= 16'h0001;
      fb_div_r <= 16'h0001;
      ref_stg_r <= 16'h0001;
      fb_stg_r <= 16'h0001;
      ref_pend_r <= 1'b0;
      fb_pend_r <= 1'b0;
      fr_r <= 1'b0;
      fv_r <= 1'b0;
    end else begin
      ref_cnt_r <= ref_cnt_nxt;
      fb_cnt_r <= fb_cnt_nxt;
      ref_div_r <= ref_div_nxt;
      fb_div_r <= fb_div_nxt;
      ref_stg_r <= ref_stg_nxt;
      fb_stg_r <= fb_stg_nxt;
      ref_pend_r <= ref_pend_nxt;
      fb_pend_r <= fb_pend_nxt;
      fr_r <= fr_nxt;
      fv_r <= fv_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_REF_KEEPS_OLD: assert property (rif.update && !ref_end |=> ref_div_r == $past(ref_div_r))
    else $error("Reference ratio changed before its cycle ended");
  AST_FB_TOTAL: assert property (rif.update |=> fb_stg_r == fb_total($past(rif.swal)))
    else $error("Feedback total is not main*64+swallow");
  AST_PEND_TAKEN: assert property (ref_pend_r && ref_end |=> ref_div_r == $past(ref_stg_r))
    else $error("Staged reference ratio not taken at cycle end");
  COV_REF_RELOAD: cover property (ref_pend_r && ref_end);
endmodule
`default_nettype wire

// *** dv/sdrl_host_model.sv ***
/*
  Host controller model: drives the serial clock, data and load strobe.
  Assumes clk at 100 ns; the serial clock runs at 800 ns only inside frames.
*/
`timescale 1ns/100ps
`default_nettype none
module sdrl_host_model (
  input wire logic clk, // System clock used for pacing
  output logic sclk, // Serial clock pin
  output logic sdata, // Serial data pin
  output logic load_strobe_n, // Load strobe pin
  input wire logic data_out // Overflow pin of the device
);
  logic [32:0] out_hist;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    load_strobe_n = 1'b1;
    out_hist = '0;
  end
  // Sends the last n bits of word, MSB first; n of 0 is a bare strobe pulse
  task automatic send_word(input logic [31:0] word, input int n);
    repeat (4) @(posedge clk);
    load_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      sdata <= word[n-1-i];
      repeat (4) @(posedge clk);
      out_hist[i] <= data_out;
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    sclk <= 1'b0;
    // Released line shows the inverse so a stale bit is never mistaken for data
    sdata <= ~sdata;
    repeat (4) @(posedge clk);
    out_hist[n] <= data_out;
    load_strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** dv/sdrl_top_tb_top.sv ***
/*
  Self-checking bench of the serial divider register loader.
  Assumes the design's AXI4-Lite map and hand-over timing.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdrl_cfg.svh"
module sdrl_top_tb_top;
  logic clk, resetn, sclk, sdata, load_strobe_n, ref_in, fb_in, data_out, f_r, f_v;
  logic [2:0] osc_sel;
  logic [1:0] div_cnt, s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch, samples_checked, gap_r, gap_v, g;
  bit arm_r;
  sdrl_host_model i_sdrl_host_model (.clk(clk), .sclk(sclk), .sdata(sdata),
    .load_strobe_n(load_strobe_n), .data_out(data_out));
  sdrl_top i_sdrl_top (.clk(clk), .resetn(resetn), .sclk(sclk), .sdata(sdata),
    .load_strobe_n(load_strobe_n), .ref_in(ref_in), .fb_in(fb_in), .data_out(data_out),
    .osc_sel(osc_sel), .f_r(f_r), .f_v(f_v), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  always #50 clk = ~clk;
  // Both count inputs see a rising edge every 4 clk
  always @(posedge clk) begin
    div_cnt <= div_cnt + 2'h1;
    ref_in <= div_cnt[1];
    fb_in <= div_cnt[1];
  end
  always @(posedge clk) begin
    gap_r <= (f_r === 1'b1) ? 1 : gap_r + 1;
    gap_v <= (f_v === 1'b1) ? 1 : gap_v + 1;
    if (arm_r && f_r === 1'b1) begin
      samples_checked++;
      if (gap_r != 28 && gap_r != 12) begin
        n_mismatch++;
        $display("Error t=%0t reference cycle of %0d clk", $time, gap_r);
      end
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk(t < 200, 1, "write answer");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(t < 200, 1, "read answer");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_rd(a, d, rsp);
    chk(d, exp, "register");
    chk(rsp, 2'b00, "read response");
  endtask
  task automatic wait_gap(input bit v, output int gg);
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while ((v ? f_v : f_r) !== 1'b1 && t < 5000);
    gg = v ? gap_v : gap_r;
    chk(t < 5000, 1, "divided pulse");
  endtask
  task automatic t_reset_values;
    logic [31:0] d;
    rd_chk(`SDRL_OFF_CFG, 32'h0);
    rd_chk(`SDRL_OFF_SWAL, 32'h41);
    rd_chk(`SDRL_OFF_REF1, 32'h1);
    rd_chk(`SDRL_OFF_REF2, 32'h1);
    rd_chk(`SDRL_OFF_CTRL, 32'h0);
    axi_rd(8'h18, d, rsp);
    chk(d, 32'h0, "unmapped data");
    chk(rsp, 2'b10, "unmapped read");
    axi_wr(8'h1C, 32'hFFFF_FFFF, rsp);
    chk(rsp, 2'b10, "unmapped write");
    // A misaligned hit on the control word must be refused and leave run off
    axi_wr(8'h11, 32'h1, rsp);
    chk(rsp, 2'b10, "unaligned write");
    rd_chk(`SDRL_OFF_CTRL, 32'h0);
    rd_chk(`SDRL_OFF_STAT, 32'h0);
  endtask
  task automatic t_cfg;
    i_sdrl_host_model.send_word(32'h5A, 8);
    rd_chk(`SDRL_OFF_CFG, 32'h5A);
    rd_chk(`SDRL_OFF_SWAL, 32'h41);
    rd_chk(`SDRL_OFF_REF1, 32'h1);
    rd_chk(`SDRL_OFF_REF2, 32'h1);
  endtask
  task automatic t_ref_chain;
    logic [31:0] w;
    w = 32'hA500_A123;
    i_sdrl_host_model.send_word(w, 32);
    chk(osc_sel, 3'h5, "select bits");
    rd_chk(`SDRL_OFF_REF1, 32'hA123);
    rd_chk(`SDRL_OFF_REF2, 32'h1);
    rd_chk(`SDRL_OFF_CFG, 32'h5A);
    rd_chk(`SDRL_OFF_SWAL, 32'h41);
    // The 25th bit onward pushes the first bits out towards the next device
    for (int k = 24; k <= 32; k++) chk(i_sdrl_host_model.out_hist[k], w[55-k], "overflow");
  endtask
  task automatic t_empty;
    i_sdrl_host_model.send_word(32'h0, 0);
    rd_chk(`SDRL_OFF_REF2, 32'h0123);
    rd_chk(`SDRL_OFF_REF1, 32'hA123);
    rd_chk(`SDRL_OFF_CFG, 32'h5A);
    rd_chk(`SDRL_OFF_SWAL, 32'h41);
  endtask
  task automatic t_swal;
    i_sdrl_host_model.send_word(32'h2007, 24);
    rd_chk(`SDRL_OFF_REF2, 32'h0123);
    i_sdrl_host_model.send_word(32'h0203, 16);
    rd_chk(`SDRL_OFF_SWAL, 32'h0203);
    rd_chk(`SDRL_OFF_REF2, 32'h0007);
    rd_chk(`SDRL_OFF_REF1, 32'h2007);
    rd_chk(`SDRL_OFF_CFG, 32'h5A);
  endtask
  task automatic t_ratio;
    axi_wr(`SDRL_OFF_CTRL, 32'h1, rsp);
    chk(rsp, 2'b00, "write response");
    rd_chk(`SDRL_OFF_CTRL, 32'h1);
    wait_gap(1'b0, g);
    wait_gap(1'b0, g);
    chk(g, 28, "reference ratio 7");
    wait_gap(1'b1, g);
    wait_gap(1'b1, g);
    chk(g, 2060, "feedback 8*64+3");
  endtask
  task automatic t_late_switch;
    i_sdrl_host_model.send_word(32'h0003, 24);
    arm_r <= 1'b1;
    i_sdrl_host_model.send_word(32'h0, 0);
    rd_chk(`SDRL_OFF_REF2, 32'h3);
    repeat (3) wait_gap(1'b0, g);
    chk(g, 12, "reference ratio 3");
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {clk, resetn, div_cnt, ref_in, fb_in, arm_r} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {n_mismatch, samples_checked, gap_r, gap_v} = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    t_reset_values();
    t_cfg();
    t_ref_chain();
    t_empty();
    t_swal();
    t_ratio();
    t_late_switch();
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
